// ---- src/ccu_consts.vh ----
/*
  Constants for the capture/compare unit: register offsets, field
  positions, reset values and mode encodings.
  Assumes inclusion by bare name from the unit's design file.
*/
`ifndef CCU_CONSTS_VH
`define CCU_CONSTS_VH

// Register offsets on the plain register port
`define CCU_OFS_CTRL 3'h0
`define CCU_OFS_VAL_LO 3'h1
`define CCU_OFS_VAL_HI 3'h2
`define CCU_OFS_PINSEL 3'h3
`define CCU_OFS_STATUS 3'h4
`define CCU_OFS_MASK 3'h5
`define CCU_OFS_TBCFG 3'h6

// Control register fields
`define CCU_MODE_MSB 3
`define CCU_MODE_LSB 0

// Status and mask bit positions
`define CCU_ST_EVENT 0
`define CCU_ST_TRIG 1

// Time base config bits
`define CCU_TB_EXTSEL 0
`define CCU_TB_RUN 1

// Reset values
`define CCU_RST_BYTE 8'h00
`define CCU_RST_WORD 16'h0000
`define CCU_RST_PRE 4'h0

// Event mode encodings
`define CCU_M_OFF 4'h0
`define CCU_M_CAP_FALL 4'h4
`define CCU_M_CAP_RISE 4'h5
`define CCU_M_CAP_RISE4 4'h6
`define CCU_M_CAP_RISE16 4'h7
`define CCU_M_CMP_SET 4'h8
`define CCU_M_CMP_CLR 4'h9
`define CCU_M_CMP_SWI 4'hA
`define CCU_M_CMP_TRIG 4'hB
`define CCU_M_CMP_TOG 4'h2

// Instruction clock divider: system clock divided by four
`define CCU_INSTR_DIV 2'h3

// Prescaler terminal counts
`define CCU_PRE_4 4'h3
`define CCU_PRE_16 4'hF

`endif

// ---- src/ccu_capture_compare.v ----
/*
  Capture/compare unit with its own 16-bit time base, register port,
  sticky event status with mask, and relocatable pins.
  Assumes the register master changes signals just after SYS_CLK rises,
  and that external pins are asynchronous to SYS_CLK.
*/
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "ccu_consts.vh"

module ccu_capture_compare (
  input wire SYS_CLK,
  input wire RST_B,
  input wire CLK_EN,
  input wire [2:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR_STB,
  input wire RD_STB,
  output reg [7:0] RDATA,
  input wire SLEEP,
  input wire EXT_CLK,
  input wire EVENT_PIN_A,
  input wire EVENT_PIN_B,
  output reg EVENT_PIN_A_OUT,
  output reg EVENT_PIN_A_OE,
  output reg EVENT_PIN_B_OUT,
  output reg EVENT_PIN_B_OE,
  output reg ADC_TRIGGER,
  output reg IRQ
);

  // Registers
  reg [7:0] ctrl_r;
  reg [7:0] val_lo_r;
  reg [7:0] val_hi_r;
  reg [7:0] pinsel_r;
  reg [1:0] status_r;
  reg [1:0] mask_r;
  reg [1:0] tbcfg_r;
  reg [15:0] count_r;
  reg [1:0] div_r;
  reg [3:0] pre_r;
  reg out_latch_r;
  reg trig_pend_r;
  reg cnt_chg_r;
  reg [2:0] pin_sync_a_r;
  reg [2:0] pin_sync_b_r;
  reg [2:0] ext_sync_r;

  wire [3:0] mode = ctrl_r[`CCU_MODE_MSB:`CCU_MODE_LSB];
  wire use_ext = tbcfg_r[`CCU_TB_EXTSEL];
  wire tb_run = tbcfg_r[`CCU_TB_RUN];
  wire is_cap = (mode[3:2] == 2'b01);
  wire is_cmp = mode[3] | (mode == `CCU_M_CMP_TOG);
  wire sel_b = pinsel_r[0];

  // Pin and external clock samples, second stage onward only
  wire pin_now = sel_b ? pin_sync_b_r[1] : pin_sync_a_r[1];
  wire pin_old = sel_b ? pin_sync_b_r[2] : pin_sync_a_r[2];
  wire pin_rise = pin_now & ~pin_old;
  wire pin_fall = ~pin_now & pin_old;
  wire ext_tick = ext_sync_r[1] & ~ext_sync_r[2];

  // Time base tick: internal source stops in sleep, external keeps going
  wire int_tick = (div_r == `CCU_INSTR_DIV) & ~SLEEP;
  wire tb_tick = tb_run & (use_ext ? ext_tick : int_tick);

  // Equality against the compare value, once per new count or value/control write
  wire cmp_equal = (count_r == {val_hi_r, val_lo_r});
  wire cmp_hit = is_cmp & cmp_equal & cnt_chg_r;

  // Capture event selection with prescaler
  reg cap_hit;
  always @*
  begin
    cap_hit = 1'b0;
    case (mode)
      `CCU_M_CAP_FALL: cap_hit = pin_fall;
      `CCU_M_CAP_RISE: cap_hit = pin_rise;
      `CCU_M_CAP_RISE4: cap_hit = pin_rise & (pre_r == `CCU_PRE_4);
      `CCU_M_CAP_RISE16: cap_hit = pin_rise & (pre_r == `CCU_PRE_16);
      default: cap_hit = 1'b0;
    endcase
  end

  wire sw_wr = WR_STB & CLK_EN;
  wire wr_ctrl = sw_wr & (ADDR == `CCU_OFS_CTRL);
  wire wr_lo = sw_wr & (ADDR == `CCU_OFS_VAL_LO);
  wire wr_hi = sw_wr & (ADDR == `CCU_OFS_VAL_HI);

  // Synchronisers: two flops before any logic, third for edge history
  always @(posedge SYS_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      pin_sync_a_r <= 3'h0;
      pin_sync_b_r <= 3'h0;
      ext_sync_r <= 3'h0;
    end
    else if (CLK_EN)
    begin
      pin_sync_a_r <= {pin_sync_a_r[1:0], EVENT_PIN_A};
      pin_sync_b_r <= {pin_sync_b_r[1:0], EVENT_PIN_B};
      ext_sync_r <= {ext_sync_r[1:0], EXT_CLK};
    end
  end

  // Software registers; control write drives the off/on sequence
  always @(posedge SYS_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      ctrl_r <= `CCU_RST_BYTE;
      pinsel_r <= `CCU_RST_BYTE;
      mask_r <= 2'h0;
      tbcfg_r <= 2'h0;
    end
    else if (CLK_EN & WR_STB)
    begin
      if (ADDR == `CCU_OFS_CTRL)
        ctrl_r <= WDATA;
      else if (ADDR == `CCU_OFS_PINSEL)
        pinsel_r <= WDATA;
      else if (ADDR == `CCU_OFS_MASK)
        mask_r <= WDATA[1:0];
      else if (ADDR == `CCU_OFS_TBCFG)
        tbcfg_r <= WDATA[1:0];
    end
  end

  // Value pair: software writes, capture overwrites the old value
  always @(posedge SYS_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      val_lo_r <= `CCU_RST_BYTE;
      val_hi_r <= `CCU_RST_BYTE;
    end
    else if (CLK_EN)
    begin
      if (cap_hit)
      begin
        val_lo_r <= count_r[7:0];
        val_hi_r <= count_r[15:8];
      end
      else
      begin
        if (wr_lo)
          val_lo_r <= WDATA;
        if (wr_hi)
          val_hi_r <= WDATA;
      end
    end
  end

  // Prescaler: cleared when off or not capturing, so mode change is safe
  always @(posedge SYS_CLK or negedge RST_B)
  begin
    if (!RST_B)
      pre_r <= `CCU_RST_PRE;
    else if (CLK_EN)
    begin
      if (!is_cap | wr_ctrl)
        pre_r <= `CCU_RST_PRE;
      else if (pin_rise)
        pre_r <= cap_hit ? `CCU_RST_PRE : pre_r + 4'h1;
    end
  end

  // Time base with count held in sleep on the internal source and deferred special reset
  always @(posedge SYS_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      div_r <= 2'h0;
      count_r <= `CCU_RST_WORD;
      trig_pend_r <= 1'b0;
      cnt_chg_r <= 1'b0;
    end
    else if (CLK_EN)
    begin
      if (!SLEEP)
        div_r <= div_r + 2'h1;
      cnt_chg_r <= tb_tick | wr_lo | wr_hi | wr_ctrl;
      if (cmp_hit & (mode == `CCU_M_CMP_TRIG))
        trig_pend_r <= 1'b1;
      else if (tb_tick | ~cmp_equal)
        trig_pend_r <= 1'b0; // Match removed cancels the reset
      if (tb_tick)
        count_r <= (trig_pend_r & cmp_equal) ? `CCU_RST_WORD
                   : count_r + 16'h0001;
    end
  end

  // Compare output latch; cleared whenever control is cleared
  always @(posedge SYS_CLK or negedge RST_B)
  begin
    if (!RST_B)
      out_latch_r <= 1'b0;
    else if (CLK_EN)
    begin
      if (mode == `CCU_M_OFF)
        out_latch_r <= 1'b0;
      else if (cmp_hit)
      begin
        case (mode)
          `CCU_M_CMP_SET: out_latch_r <= 1'b1;
          `CCU_M_CMP_CLR: out_latch_r <= 1'b0;
          `CCU_M_CMP_TOG: out_latch_r <= ~out_latch_r;
          default: out_latch_r <= out_latch_r;
        endcase
      end
    end
  end

  // Pin drive: only set/clear/toggle modes own the pin, routed by select
  wire drive_pin = (mode == `CCU_M_CMP_SET) | (mode == `CCU_M_CMP_CLR)
                   | (mode == `CCU_M_CMP_TOG);
  always @(posedge SYS_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      EVENT_PIN_A_OUT <= 1'b0;
      EVENT_PIN_A_OE <= 1'b0;
      EVENT_PIN_B_OUT <= 1'b0;
      EVENT_PIN_B_OE <= 1'b0;
    end
    else if (CLK_EN)
    begin
      EVENT_PIN_A_OUT <= out_latch_r;
      EVENT_PIN_B_OUT <= out_latch_r;
      EVENT_PIN_A_OE <= drive_pin & ~sel_b;
      EVENT_PIN_B_OE <= drive_pin & sel_b;
    end
  end

  // Sticky status; a new event wins over a same-cycle write-one clear
  wire [1:0] ev_set;
  assign ev_set[`CCU_ST_EVENT] = cmp_hit | cap_hit;
  assign ev_set[`CCU_ST_TRIG] = cmp_hit & (mode == `CCU_M_CMP_TRIG);
  wire [1:0] ev_clr = (sw_wr & (ADDR == `CCU_OFS_STATUS)) ?
                      WDATA[1:0] : 2'h0;
  wire [1:0] status_nxt = (status_r & ~ev_clr) | ev_set;
  always @(posedge SYS_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      status_r <= 2'h0;
      IRQ <= 1'b0;
      ADC_TRIGGER <= 1'b0;
    end
    else if (CLK_EN)
    begin
      status_r <= status_nxt;
      IRQ <= |(status_nxt & mask_r);
      ADC_TRIGGER <= ev_set[`CCU_ST_TRIG];
    end
  end

  // Read port: data valid in the cycle after the strobe
  always @(posedge SYS_CLK or negedge RST_B)
  begin
    if (!RST_B)
      RDATA <= `CCU_RST_BYTE;
    else if (CLK_EN)
    begin
      if (!RD_STB)
        RDATA <= `CCU_RST_BYTE;
      else if (ADDR == `CCU_OFS_CTRL)
        RDATA <= ctrl_r;
      else if (ADDR == `CCU_OFS_VAL_LO)
        RDATA <= val_lo_r;
      else if (ADDR == `CCU_OFS_VAL_HI)
        RDATA <= val_hi_r;
      else if (ADDR == `CCU_OFS_PINSEL)
        RDATA <= pinsel_r;
      else if (ADDR == `CCU_OFS_STATUS)
        RDATA <= {6'h00, status_r};
      else if (ADDR == `CCU_OFS_MASK)
        RDATA <= {6'h00, mask_r};
      else if (ADDR == `CCU_OFS_TBCFG)
        RDATA <= {6'h00, tbcfg_r};
      else
        RDATA <= count_r[7:0]; // Offset 7: live count low byte
    end
  end

endmodule // ccu_capture_compare

// ---- verification/ccu_far_end.sv ----
/*
  Far-side model: event pin and external time-base clock.
  Assumes the bench calls its tasks; both lines rest low between bursts.
*/
`timescale 1ns/1ps
module ccu_far_end (
  output logic ext_clk,
  output logic pin
);
  // Lines idle low; the clock only runs on request
  initial
  begin
    ext_clk = 1'b0;
    pin = 1'b0;
  end
  // One clock rise; h sets prompt or slow edges
  task tick(input int h);
    ext_clk = 1'b1;
    #h;
    ext_clk = 1'b0;
    #h;
  endtask
  // Full pulses, rise then fall, each one rising and one falling pin edge
  task pulses(input int n, input int h);
    repeat (n)
    begin
      pin = 1'b1;
      #h;
      pin = 1'b0;
      #h;
    end
  endtask
endmodule // ccu_far_end

// ---- verification/ccu_capture_compare_assertions.sv ----
/*
  Port checker for the capture/compare unit.
  Assumes it is bound to the top module and sees its ports only.
*/
`timescale 1ns/1ps
module ccu_checker (
  input wire SYS_CLK,
  input wire RST_B,
  input wire CLK_EN,
  input wire [2:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR_STB,
  input wire RD_STB,
  input wire [7:0] RDATA,
  input wire EVENT_PIN_A_OUT,
  input wire EVENT_PIN_A_OE,
  input wire EVENT_PIN_B_OUT,
  input wire EVENT_PIN_B_OE,
  input wire ADC_TRIGGER,
  input wire IRQ
);
  // Taken writes to control and mask
  wire wc = WR_STB && CLK_EN && ADDR == 3'h0;
  wire wm = WR_STB && CLK_EN && ADDR == 3'h5;
  wire oe = EVENT_PIN_A_OE || EVENT_PIN_B_OE;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);
  a_rd_one_slot: assert property (CLK_EN && !RD_STB |=> RDATA == 8'h00)
    else $error("read data outside its slot");
  a_trig_one_pulse: assert property (ADC_TRIGGER && CLK_EN
    |=> !ADC_TRIGGER)
    else $error("trigger pulse too long");
  a_trig_no_pin: assert property (ADC_TRIGGER |-> !oe)
    else $error("pin driven in trigger mode");
  a_pin_one_site: assert property (!(EVENT_PIN_A_OE && EVENT_PIN_B_OE))
    else $error("both pin sites driven");
  a_mask_off_irq: assert property (wm && WDATA == 8'h00 ##1 !wm |=> !IRQ)
    else $error("interrupt with mask clear");
  a_reset_quiet: assert property ($rose(RST_B) |->
    !(IRQ || ADC_TRIGGER || oe || RDATA != 8'h00))
    else $error("output active after reset");
  a_off_pin_low: assert property (wc && WDATA == 8'h00 ##1 !wc |=> ##1
    !(oe || EVENT_PIN_A_OUT || EVENT_PIN_B_OUT))
    else $error("pin not released when off");
  a_swi_no_pin: assert property (wc && WDATA[3:0] == 4'hA
    ##1 !wc [*2] |=> !oe)
    else $error("pin driven in interrupt mode");
  a_freeze_outs: assert property (!CLK_EN |=> $stable(RDATA) &&
    $stable(IRQ) && $stable(EVENT_PIN_B_OUT))
    else $error("outputs moved while frozen");
endmodule // ccu_checker
bind ccu_capture_compare ccu_checker ccu_checker_i (
  .SYS_CLK(SYS_CLK), .RST_B(RST_B), .CLK_EN(CLK_EN), .ADDR(ADDR),
  .WDATA(WDATA), .WR_STB(WR_STB), .RD_STB(RD_STB), .RDATA(RDATA),
  .EVENT_PIN_A_OUT(EVENT_PIN_A_OUT), .EVENT_PIN_A_OE(EVENT_PIN_A_OE),
  .EVENT_PIN_B_OUT(EVENT_PIN_B_OUT), .EVENT_PIN_B_OE(EVENT_PIN_B_OE),
  .ADC_TRIGGER(ADC_TRIGGER), .IRQ(IRQ)
);

// ---- verification/testbench.sv ----
/*
  Self-checking bench for the capture/compare unit.
  Assumes the far-side model drives the event pin and external clock.
*/
`timescale 1ns/1ps
`include "ccu_consts.vh"
module testbench;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic clk_en = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic sleep = 1'b0;
  logic trig_seen = 1'b0;
  logic [31:0] lfsr = 32'hCD338FCA;
  logic [7:0] rdata, c, d;
  logic [1:0] e;
  logic ext_clk, far_pin, irq, adc_trig, a_out, a_oe, b_out, b_oe;
  logic [3:0] cmp_m [5] = '{`CCU_M_CMP_SET, `CCU_M_CMP_CLR,
    `CCU_M_CMP_TOG, `CCU_M_CMP_SWI, `CCU_M_CMP_TRIG};
  logic [3:0] cap_m [4] = '{`CCU_M_CAP_FALL, `CCU_M_CAP_RISE,
    `CCU_M_CAP_RISE4, `CCU_M_CAP_RISE16};
  int ecnt [4] = '{1, 1, 4, 16};
  int mismatches = 0;
  int total_checks = 0;
  always #50 sys_clk = ~sys_clk;
  // Captures use site B; site A gets the external clock as a decoy
  ccu_capture_compare ccu_capture_compare_i (.SYS_CLK(sys_clk),
    .RST_B(rst_b), .CLK_EN(clk_en), .ADDR(addr), .WDATA(wdata),
    .WR_STB(wr_stb), .RD_STB(rd_stb), .RDATA(rdata), .SLEEP(sleep),
    .EXT_CLK(ext_clk), .EVENT_PIN_A(ext_clk), .EVENT_PIN_B(far_pin),
    .EVENT_PIN_A_OUT(a_out), .EVENT_PIN_A_OE(a_oe),
    .EVENT_PIN_B_OUT(b_out), .EVENT_PIN_B_OE(b_oe),
    .ADC_TRIGGER(adc_trig), .IRQ(irq));
  ccu_far_end ccu_far_end_i (.ext_clk(ext_clk), .pin(far_pin));
  // One-cycle trigger is latched here so it cannot be missed
  always @(posedge sys_clk)
    if (adc_trig)
      trig_seen <= 1'b1;
  function automatic [31:0] nxt(input [31:0] s);
    nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Expected {drive, level} of the pin after a match, latch low first
  function automatic [1:0] pin_exp(input [3:0] m);
    pin_exp = (m == `CCU_M_CMP_SET || m == `CCU_M_CMP_TOG) ? 2'b11 :
      (m == `CCU_M_CMP_CLR) ? 2'b10 : 2'b00;
  endfunction
  task chk(input [7:0] g, input [7:0] x);
    total_checks++;
    if (g !== x)
    begin
      mismatches++;
      $display("ERROR t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task wr(input [2:0] a, input [7:0] v);
    @(posedge sys_clk);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
  endtask
  // Data stand only in the cycle after the strobe
  task rd(input [2:0] a, output [7:0] v);
    @(posedge sys_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    @(negedge sys_clk);
    v = rdata;
  endtask
  task rc(input [2:0] a, input [7:0] x);
    rd(a, d);
    chk(d, x);
  endtask
  task stop_test;
    if (mismatches == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Watchdog: run needs well under 10k cycles
  initial
  begin
    #2000000;
    mismatches++;
    stop_test;
  end
  initial
  begin
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 8; i++)
      rc(i[2:0], 8'h00);
    repeat (4)
    begin
      lfsr = nxt(lfsr);
      wr(3'h1, lfsr[7:0]);
      wr(3'h2, lfsr[15:8]);
      rc(3'h1, lfsr[7:0]);
      rc(3'h2, lfsr[15:8]);
    end
    wr(3'h2, 8'h00);
    wr(3'h3, 8'h01);
    wr(3'h5, 8'h01);
    wr(3'h6, 8'h02);
    // Each compare mode fires once on a value ahead of the count
    for (int i = 0; i < 5; i++)
    begin
      wr(3'h1, 8'((i + 1) * 32));
      wr(3'h0, {4'h0, cmp_m[i]});
      for (int k = 0; k < 400 && irq !== 1'b1; k++)
        @(negedge sys_clk);
      chk({7'h00, irq}, 8'h01);
      wr(3'h4, 8'h03);
      @(negedge sys_clk);
      e = pin_exp(cmp_m[i]);
      chk({5'h00, a_oe, b_oe, b_out & e[1]}, {6'h00, e});
      chk({7'h00, a_out & e[1]}, {7'h00, e[0]});
      repeat (6) @(posedge sys_clk);
      rc(3'h4, 8'h00);
    end
    chk({7'h00, trig_seen}, 8'h01);
    rd(3'h7, d);
    chk({7'h00, d < 8'h04}, 8'h01);
    // Freeze, then sleep on the instruction clock
    @(posedge sys_clk);
    clk_en <= 1'b0;
    repeat (3) @(posedge sys_clk);
    clk_en <= 1'b1;
    sleep <= 1'b1;
    rd(3'h7, c);
    repeat (40) @(posedge sys_clk);
    rc(3'h7, c);
    @(posedge sys_clk);
    sleep <= 1'b0;
    rd(3'h7, d);
    chk({7'h00, 8'(d - c) <= 8'h01}, 8'h01);
    c = d;
    repeat (10) @(posedge sys_clk);
    rc(3'h7, 8'(c + 3));
    // Captures on the external clock while asleep, interrupt masked
    wr(3'h5, 8'h00);
    sleep <= 1'b1;
    wr(3'h6, 8'h03);
    for (int i = 0; i < 4; i++)
    begin
      wr(3'h0, 8'h00);
      wr(3'h0, {4'h0, cap_m[i]});
      rd(3'h7, c);
      for (int r = 1; r < 3; r++)
      begin
        wr(3'h4, 8'h03);
        ccu_far_end_i.tick(r * 437);
        ccu_far_end_i.pulses(ecnt[i] - 1, 437);
        rc(3'h4, 8'h00);
        ccu_far_end_i.pulses(1, r * 437);
        rc(3'h1, 8'(c + r));
        rc(3'h4, 8'h01);
        chk({7'h00, irq}, 8'h00);
      end
    end
    wr(3'h5, 8'h01);
    repeat (2) @(negedge sys_clk);
    chk({7'h00, irq}, 8'h01);
    wr(3'h4, 8'h01);
    repeat (2) @(negedge sys_clk);
    chk({7'h00, irq}, 8'h00);
    stop_test;
  end
endmodule // testbench
